/* core/sadc_consts.vh */
// Register map, field positions, reset values and counts of the converter.
`ifndef SADC_CONSTS_VH
`define SADC_CONSTS_VH
`define SADC_ADDR_CFG    8'hbc
`define SADC_ADDR_RES_LO 8'hbe
`define SADC_ADDR_RES_HI 8'hbf
`define SADC_ADDR_CTL    8'he8
`define SADC_CFG_RST     8'hf8
`define SADC_CTL_RST     8'h00
`define SADC_RES_RST     8'h00
`define SADC_RD_NONE     8'h00
`define SADC_CFG_DIV_HI  7
`define SADC_CFG_DIV_LO  3
`define SADC_CFG_GAIN_HI 2
`define SADC_CFG_GAIN_LO 0
`define SADC_CTL_EN      7
`define SADC_CTL_TM      6
`define SADC_CTL_DONE    5
`define SADC_CTL_BUSY    4
`define SADC_CTL_CM_HI   3
`define SADC_CTL_CM_LO   2
`define SADC_CTL_WIN     1
`define SADC_CTL_LJST    0
`define SADC_CM_SW       2'h0
`define SADC_CM_T3       2'h1
`define SADC_CM_EXT      2'h2
`define SADC_CM_T2       2'h3
`define SADC_TRACK_CLKS  5'h03
`define SADC_CONV_CLKS   5'h10
`define SADC_DIV_ZERO    5'h00
`define SADC_CNT_ONE     5'h01
`define SADC_LJ_PAD      6'h00
`define SADC_GAIN_X1     6'h01
`define SADC_GAIN_X2     6'h02
`define SADC_GAIN_X4     6'h04
`define SADC_GAIN_X8     6'h08
`define SADC_GAIN_X16    6'h10
`define SADC_GAIN_XHALF  6'h20
`define SADC_ST_IDLE     2'h0
`define SADC_ST_TRACK    2'h1
`define SADC_ST_CONV     2'h2
`endif

/* core/sadc_top.v */
// Control, sequencing, formatting and window detect of a 10-bit SAR ADC.
//
// What this block does
// - Converter clock is system clock over divider+1.
// - Gain field decodes to x1,2,4,8,16,0.5.
// - Enable low holds converter in shutdown.
// - Track mode zero tracks continuously when idle.
// - Done flag sets at busy fall; software clears.
// - Busy reads one only during low-power tracking and conversion.
// - Busy write one starts only in mode 00.
// - Start mode picks software, timer3, pin, timer2.
// - Low-power tracking lasts exactly three converter clocks, except in pin mode.
// - Pin mode tracks while low, converts on rise.
// - Window flag sets on match, software clears.
// - Justify bit selects right or left placement.
// - Right form: high bits sign or zero extended.
// - Left form: low byte bits 5..0 zero.
// - Single-ended results are plain unsigned codes.
// - Differential results are two's complement, sign extended.
// - Every result compared against both limit words.
// - Inside or outside set by limit ordering.
// - Less above greater means strictly between; else outside.
// - Busy covers the whole conversion, any source.
// - Conversion lasts sixteen converter clocks after tracking.
`timescale 1ns/1ps
`include "sadc_consts.vh"
module sadc_top (
	input  wire        clk_i,
	input  wire        rst_n_i,
	input  wire [7:0]  sfr_addr_i,
	input  wire        sfr_wr_i,
	input  wire [7:0]  sfr_wdata_i,
	output reg  [7:0]  sfr_rdata_o,
	input  wire        t3_ovf_i,
	input  wire        t2_ovf_i,
	input  wire        ext_start_i,
	input  wire        diff_mode_i,
	input  wire [15:0] greater_limit_i,
	input  wire [15:0] less_limit_i,
	input  wire [9:0]  sar_code_i,
	output reg         conv_clk_o,
	output reg         track_o,
	output reg         convert_o,
	output reg         shutdown_o,
	output reg  [5:0]  pga_gain_o
);

	reg        rst_meta_q;
	reg        rst_sync_q;
	wire       rst_n;
	reg  [7:0] cfg_q;
	reg        en_q;
	reg        tm_q;
	reg        done_q;
	reg  [1:0] cm_q;
	reg        win_q;
	reg        ljst_q;
	reg  [7:0] res_lo_q;
	reg  [7:0] res_hi_q;
	reg  [1:0] state_q;
	reg  [1:0] state_d;
	reg  [4:0] cyc_q;
	reg  [4:0] cyc_d;
	reg  [4:0] div_cnt_q;
	reg        pin_meta_q;
	reg        pin_sync_q;
	reg        pin_last_q;
	reg        start_ev;
	reg  [5:0] gain_d;
	reg  [7:0] rdata_d;
	reg  [15:0] word;
	reg        win_hit;
	wire [4:0] div;
	wire       ctl_wr;
	wire       sw_start;
	wire       pin_rise;
	wire       idle;
	wire       busy;
	wire       done_ev;
	wire       track_d;
	wire [15:0] w_k;
	wire [15:0] gt_k;
	wire [15:0] lt_k;

	// Reset is asserted at once but released through two flops.
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	assign rst_n = rst_sync_q;

	assign div    = cfg_q[`SADC_CFG_DIV_HI:`SADC_CFG_DIV_LO];
	assign ctl_wr = sfr_wr_i && (sfr_addr_i == `SADC_ADDR_CTL);
	assign idle   = (state_q == `SADC_ST_IDLE);
	assign busy   = !idle;

	// The write itself must carry enable and software mode, and the block
	// must already be enabled in software mode, so a stray busy write made
	// while changing modes cannot start a conversion.
	assign sw_start = ctl_wr && sfr_wdata_i[`SADC_CTL_BUSY] &&
		sfr_wdata_i[`SADC_CTL_EN] &&
		(sfr_wdata_i[`SADC_CTL_CM_HI:`SADC_CTL_CM_LO] == `SADC_CM_SW);

	// Only the second flop of the pin synchroniser feeds the edge detector.
	// A pin that idles high shows one false edge after reset; it is harmless
	// because every start is refused until software sets the enable.
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
			pin_last_q <= 1'b0;
		end else begin
			pin_meta_q <= ext_start_i;
			pin_sync_q <= pin_meta_q;
			pin_last_q <= pin_sync_q;
		end
	end
	assign pin_rise = pin_sync_q && !pin_last_q;

	always @* begin
		case (cm_q)
		`SADC_CM_SW:  start_ev = sw_start;
		`SADC_CM_T3:  start_ev = t3_ovf_i;
		`SADC_CM_EXT: start_ev = pin_rise;
		`SADC_CM_T2:  start_ev = t2_ovf_i;
		default:      start_ev = 1'b0;
		endcase
		start_ev = start_ev && en_q && idle;
	end

	// The divider restarts on each start so phase lengths are exact.
	// It runs while enabled, between conversions too, so the core sees a
	// steady converter clock.
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt_q  <= `SADC_DIV_ZERO;
			conv_clk_o <= 1'b0;
		end else begin
			if (!en_q || start_ev || div_cnt_q == div) begin
				div_cnt_q <= `SADC_DIV_ZERO;
			end else begin
				div_cnt_q <= div_cnt_q + `SADC_CNT_ONE;
			end
			conv_clk_o <= en_q && !start_ev && (div_cnt_q == div);
		end
	end

	assign done_ev = (state_q == `SADC_ST_CONV) && conv_clk_o &&
		(cyc_q == `SADC_CONV_CLKS - `SADC_CNT_ONE);

	// Phase lengths count converter clock pulses, not system clocks, so
	// they scale with the divider.
	always @* begin
		state_d = state_q;
		cyc_d   = cyc_q;
		case (state_q)
		`SADC_ST_IDLE: begin
			cyc_d = `SADC_DIV_ZERO;
			if (start_ev) begin
				if (tm_q && cm_q != `SADC_CM_EXT) begin
					state_d = `SADC_ST_TRACK;
				end else begin
					state_d = `SADC_ST_CONV;
				end
			end
		end
		`SADC_ST_TRACK: begin
			if (conv_clk_o) begin
				if (cyc_q == `SADC_TRACK_CLKS - `SADC_CNT_ONE) begin
					state_d = `SADC_ST_CONV;
					cyc_d   = `SADC_DIV_ZERO;
				end else begin
					cyc_d = cyc_q + `SADC_CNT_ONE;
				end
			end
		end
		`SADC_ST_CONV: begin
			if (conv_clk_o) begin
				if (done_ev) begin
					state_d = `SADC_ST_IDLE;
					cyc_d   = `SADC_DIV_ZERO;
				end else begin
					cyc_d = cyc_q + `SADC_CNT_ONE;
				end
			end
		end
		default: begin
			state_d = `SADC_ST_IDLE;
			cyc_d   = `SADC_DIV_ZERO;
		end
		endcase
		// Clearing the enable abandons a conversion without a result.
		if (!en_q) begin
			state_d = `SADC_ST_IDLE;
			cyc_d   = `SADC_DIV_ZERO;
		end
	end

	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= `SADC_ST_IDLE;
			cyc_q   <= `SADC_DIV_ZERO;
		end else begin
			state_q <= state_d;
			cyc_q   <= cyc_d;
		end
	end

	always @* begin
		if (ljst_q) begin
			word = {sar_code_i, `SADC_LJ_PAD};
		end else begin
			// Sign copy only for differential data; zeros otherwise.
			word = {{6{diff_mode_i & sar_code_i[9]}}, sar_code_i};
		end
	end

	// Flipping the top bit turns a signed compare into an unsigned one.
	assign w_k  = {word[15] ^ diff_mode_i, word[14:0]};
	assign gt_k = {greater_limit_i[15] ^ diff_mode_i,
		greater_limit_i[14:0]};
	assign lt_k = {less_limit_i[15] ^ diff_mode_i, less_limit_i[14:0]};

	// Equal limits fall to the outside test, which flags every result but
	// the one equal to both limits.
	always @* begin
		if (lt_k > gt_k) begin
			win_hit = (w_k < lt_k) && (w_k > gt_k);
		end else begin
			win_hit = (w_k < lt_k) || (w_k > gt_k);
		end
	end

	// A divider lowered mid-count can stretch one converter clock period,
	// since the count then has to wrap before it matches again.
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= `SADC_CFG_RST;
		end else if (sfr_wr_i && sfr_addr_i == `SADC_ADDR_CFG) begin
			cfg_q <= sfr_wdata_i;
		end
	end

	// Hardware setting of either flag beats a software clear.
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			en_q   <= 1'b0;
			tm_q   <= 1'b0;
			done_q <= 1'b0;
			cm_q   <= `SADC_CM_SW;
			win_q  <= 1'b0;
			ljst_q <= 1'b0;
		end else begin
			if (ctl_wr) begin
				en_q   <= sfr_wdata_i[`SADC_CTL_EN];
				tm_q   <= sfr_wdata_i[`SADC_CTL_TM];
				cm_q   <= sfr_wdata_i[`SADC_CTL_CM_HI:`SADC_CTL_CM_LO];
				ljst_q <= sfr_wdata_i[`SADC_CTL_LJST];
			end
			if (done_ev) begin
				done_q <= 1'b1;
			end else if (ctl_wr) begin
				done_q <= sfr_wdata_i[`SADC_CTL_DONE];
			end
			if (done_ev && win_hit) begin
				win_q <= 1'b1;
			end else if (ctl_wr) begin
				win_q <= sfr_wdata_i[`SADC_CTL_WIN];
			end
		end
	end

	// A finishing conversion overwrites any software write to the pair.
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			res_lo_q <= `SADC_RES_RST;
			res_hi_q <= `SADC_RES_RST;
		end else if (done_ev) begin
			res_lo_q <= word[7:0];
			res_hi_q <= word[15:8];
		end else if (sfr_wr_i) begin
			if (sfr_addr_i == `SADC_ADDR_RES_LO) begin
				res_lo_q <= sfr_wdata_i;
			end
			if (sfr_addr_i == `SADC_ADDR_RES_HI) begin
				res_hi_q <= sfr_wdata_i;
			end
		end
	end

	// One-hot gain spares the amplifier a decoder of its own.
	always @* begin
		case (cfg_q[`SADC_CFG_GAIN_HI:`SADC_CFG_GAIN_LO])
		3'h0:    gain_d = `SADC_GAIN_X1;
		3'h1:    gain_d = `SADC_GAIN_X2;
		3'h2:    gain_d = `SADC_GAIN_X4;
		3'h3:    gain_d = `SADC_GAIN_X8;
		3'h4:    gain_d = `SADC_GAIN_X16;
		3'h5:    gain_d = `SADC_GAIN_X16;
		3'h6:    gain_d = `SADC_GAIN_XHALF;
		3'h7:    gain_d = `SADC_GAIN_XHALF;
		default: gain_d = `SADC_GAIN_X1;
		endcase
	end

	// Read data is registered: it shows the register addressed one cycle
	// earlier, and reading has no side effects.
	always @* begin
		case (sfr_addr_i)
		`SADC_ADDR_CFG:    rdata_d = cfg_q;
		`SADC_ADDR_RES_LO: rdata_d = res_lo_q;
		`SADC_ADDR_RES_HI: rdata_d = res_hi_q;
		`SADC_ADDR_CTL:    rdata_d = {en_q, tm_q, done_q, busy,
			cm_q, win_q, ljst_q};
		default:           rdata_d = `SADC_RD_NONE;
		endcase
	end

	// Pin-driven low-power mode tracks only while the pin is low.
	assign track_d = en_q && ((idle && !tm_q) ||
		(state_q == `SADC_ST_TRACK) ||
		(idle && tm_q && cm_q == `SADC_CM_EXT && !pin_sync_q));

	// Every output comes from a flop so the analog side sees no decode
	// glitches.
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sfr_rdata_o <= `SADC_RD_NONE;
			track_o     <= 1'b0;
			convert_o   <= 1'b0;
			shutdown_o  <= 1'b1;
			pga_gain_o  <= `SADC_GAIN_X1;
		end else begin
			sfr_rdata_o <= rdata_d;
			track_o     <= track_d;
			convert_o   <= (state_q == `SADC_ST_CONV);
			shutdown_o  <= !en_q;
			pga_gain_o  <= gain_d;
		end
	end

endmodule

/* tb/sadc_core_model.sv */
// Behavioural SAR core that feeds the raw code back to the block.
`timescale 1ns/1ps
module sadc_core_model (
	input  wire       clk_i,
	input  wire       convert_i,
	input  wire [9:0] code_i,
	output reg  [9:0] code_o
);
	// Outside conversion the code toggles, so a stale sample cannot match.
	initial code_o = 10'h000;
	always @(posedge clk_i) begin
		code_o <= convert_i ? code_i : ~code_o;
	end
endmodule

/* tb/sadc_top_sva.sv */
// Port-level assertions for the converter control block.
`timescale 1ns/1ps
`include "sadc_consts.vh"
module sadc_top_sva (
	input wire        clk_i,
	input wire        rst_n_i,
	input wire [7:0]  sfr_addr_i,
	input wire        sfr_wr_i,
	input wire [7:0]  sfr_wdata_i,
	input wire [7:0]  sfr_rdata_o,
	input wire        t3_ovf_i,
	input wire        t2_ovf_i,
	input wire        ext_start_i,
	input wire        diff_mode_i,
	input wire [15:0] greater_limit_i,
	input wire [15:0] less_limit_i,
	input wire [9:0]  sar_code_i,
	input wire        conv_clk_o,
	input wire        track_o,
	input wire        convert_o,
	input wire        shutdown_o,
	input wire [5:0]  pga_gain_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	wire cw = sfr_wr_i && sfr_addr_i == `SADC_ADDR_CTL;
	wire fw = sfr_wr_i && sfr_addr_i == `SADC_ADDR_CFG;
	wire mp = sfr_addr_i == `SADC_ADDR_CFG || sfr_addr_i == `SADC_ADDR_CTL
		|| sfr_addr_i == `SADC_ADDR_RES_LO || sfr_addr_i == `SADC_ADDR_RES_HI;
	AST_GAIN_HOT: assert property ($onehot(pga_gain_o))
		else $error("gain select not one-hot");
	AST_GAIN_X16: assert property (fw && sfr_wdata_i[2:1] == 2'h2
		|-> ##[1:2] pga_gain_o == `SADC_GAIN_X16) else $error("gain not x16");
	AST_GAIN_HALF: assert property (fw && sfr_wdata_i[2:1] == 2'h3
		|-> ##[1:2] pga_gain_o == `SADC_GAIN_XHALF) else $error("gain not half");
	AST_CFG_RD: assert property (fw ##1 (!sfr_wr_i &&
		sfr_addr_i == `SADC_ADDR_CFG) |=> sfr_rdata_o == $past(sfr_wdata_i, 2))
		else $error("config readback wrong");
	AST_UNMAP: assert property (!mp |=> sfr_rdata_o == `SADC_RD_NONE)
		else $error("unmapped read not zero");
	AST_SHUT_ON: assert property (cw && !sfr_wdata_i[7]
		|-> ##[1:3] shutdown_o) else $error("no shutdown when disabled");
	AST_SHUT_OFF: assert property (cw && sfr_wdata_i[7]
		|-> ##[1:3] !shutdown_o) else $error("shutdown while enabled");
	AST_CONV_EN: assert property ($rose(convert_o) |-> !shutdown_o)
		else $error("conversion in shutdown");
	AST_CONV_MIN: assert property ($rose(convert_o) |-> convert_o[*8])
		else $error("conversion too short");
	AST_END_TICK: assert property ($fell(convert_o) |->
		$past(conv_clk_o) || $past(conv_clk_o, 2)) else $error("end off tick");
	cover property ($fell(convert_o));
	cover property (track_o && !convert_o);
	cover property (cw && sfr_wdata_i[7]);
endmodule
bind sadc_top sadc_top_sva u_sva (.*);

/* tb/sadc_top_tb_top.sv */
// Register-level bench of the converter control block.
`timescale 1ns/1ps
`include "sadc_consts.vh"
module sadc_top_tb_top;
	reg        clk = 1'b0;
	reg        rst_n = 1'b0;
	reg  [7:0] addr = 8'h00;
	reg        wr = 1'b0;
	reg  [7:0] wd = 8'h00;
	reg        t3 = 1'b0;
	reg        t2 = 1'b0;
	reg        ext = 1'b0;
	reg        dif = 1'b0;
	reg [15:0] gt = 16'h0000;
	reg [15:0] lt = 16'h0000;
	reg  [9:0] code = 10'h000;
	wire [7:0] rdat;
	wire [9:0] sar;
	wire       cclk;
	wire       trk;
	wire       cnv;
	wire       shut;
	wire [5:0] gain;
	integer    errors = 0;
	integer    cmp_count = 0;
	integer    pulses = 0;
	integer    i;
	reg  [7:0] v;
	reg  [7:0] h;
	reg        lp = 1'b0;
	always #2.5 clk = ~clk;
	// Count converter clocks of the tracking and conversion phases only;
	// the divider also runs between conversions.
	always @(negedge clk)
		if (cclk && (cnv || (trk && lp)))
			pulses = pulses + 1;
	sadc_top u_dut (.clk_i(clk), .rst_n_i(rst_n), .sfr_addr_i(addr),
		.sfr_wr_i(wr), .sfr_wdata_i(wd), .sfr_rdata_o(rdat), .t3_ovf_i(t3),
		.t2_ovf_i(t2), .ext_start_i(ext), .diff_mode_i(dif),
		.greater_limit_i(gt), .less_limit_i(lt), .sar_code_i(sar),
		.conv_clk_o(cclk), .track_o(trk), .convert_o(cnv),
		.shutdown_o(shut), .pga_gain_o(gain));
	sadc_core_model u_core (.clk_i(clk), .convert_i(cnv), .code_i(code),
		.code_o(sar));
	task chk(input [15:0] s, input [15:0] e);
		begin
			cmp_count = cmp_count + 1;
			if (s !== e) begin
				errors = errors + 1;
				$display("unexpected at %0t: saw %h want %h", $time, s, e);
			end
		end
	endtask
	task wr_r(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk) #1 addr = a;
			wd = d;
			wr = 1'b1;
			@(posedge clk) #1 wr = 1'b0;
		end
	endtask
	task rd_r(input [7:0] a, output [7:0] d);
		begin
			@(posedge clk) #1 addr = a;
			@(posedge clk) #1 d = rdat;
		end
	endtask
	task finish_test;
		begin
			$display("compares %0d mismatches %0d", cmp_count, errors);
			if (errors == 0 && cmp_count > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	// One conversion: set up, try a busy write, trigger, poke, then verify.
	task run(input [7:0] c, input [9:0] k, input d, input [15:0] g,
		input [15:0] l, input [15:0] w, input win, input [5:0] p);
		integer n;
		begin
			code = k;
			dif = d;
			gt = g;
			lt = l;
			ext = 1'b0;
			lp = c[6] && c[3:2] != `SADC_CM_EXT;
			wr_r(`SADC_ADDR_CTL, c);
			rd_r(`SADC_ADDR_CTL, v);
			chk(v, c);
			chk(trk, !c[6] || c[3:2] == `SADC_CM_EXT);
			pulses = 0;
			wr_r(`SADC_ADDR_CTL, c | 8'h10);
			rd_r(`SADC_ADDR_CTL, v);
			chk(v[4], c[3:2] == `SADC_CM_SW);
			case (c[3:2])
			`SADC_CM_T3: t3 = 1'b1;
			`SADC_CM_EXT: ext = 1'b1;
			`SADC_CM_T2: t2 = 1'b1;
			default: ;
			endcase
			@(posedge clk) #1 t3 = 1'b0;
			t2 = 1'b0;
			repeat (6) @(posedge clk);
			rd_r(`SADC_ADDR_CTL, v);
			chk(v[4], 1'b1);
			t3 = 1'b1;
			t2 = 1'b1;
			@(posedge clk) #1 t3 = 1'b0;
			t2 = 1'b0;
			n = 0;
			while (!v[5] && n < 200) begin
				rd_r(`SADC_ADDR_CTL, v);
				n = n + 1;
			end
			// A run that never completes counts once; the run goes on.
			if (!v[5]) begin
				errors = errors + 1;
				$display("unexpected at %0t: no completion", $time);
			end
			chk(pulses[15:0], {10'h000, p});
			rd_r(`SADC_ADDR_CTL, v);
			chk(v, c | 8'h20 | {6'h00, win, 1'b0});
			rd_r(`SADC_ADDR_RES_HI, h);
			rd_r(`SADC_ADDR_RES_LO, v);
			chk({h, v}, w);
			$display("conversion test done");
		end
	endtask
	initial begin
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (3) @(posedge clk);
		rd_r(`SADC_ADDR_CFG, v);
		chk(v, `SADC_CFG_RST);
		rd_r(`SADC_ADDR_CTL, v);
		chk(v, `SADC_CTL_RST);
		rd_r(8'h10, v);
		chk(v, `SADC_RD_NONE);
		chk(shut, 1'b1);
		$display("reset test done");
		for (i = 0; i < 8; i = i + 1) begin
			wr_r(`SADC_ADDR_CFG, 8'h08 | i[2:0]);
			#11 chk(gain, i[2] ? (i[1] ? `SADC_GAIN_XHALF : `SADC_GAIN_X16)
				: `SADC_GAIN_X1 << i[1:0]);
		end
		$display("gain test done");
		run(8'h80, 10'h3ff, 0, 16'h0100, 16'h0200, 16'h03ff, 0, 16);
		run(8'hc5, 10'h3ff, 0, 16'h0100, 16'h0200, 16'hffc0, 0, 19);
		run(8'h88, 10'h200, 1, 16'h0100, 16'h0000, 16'hfe00, 1, 16);
		run(8'hcc, 10'h1ff, 1, 16'h0100, 16'h0200, 16'h01ff, 1, 19);
		run(8'hc8, 10'h100, 0, 16'h0100, 16'h0200, 16'h0100, 0, 16);
		wr_r(`SADC_ADDR_CTL, 8'h10);
		rd_r(`SADC_ADDR_CTL, v);
		chk(v, `SADC_CTL_RST);
		chk(shut, 1'b1);
		chk(trk, 1'b0);
		$display("shutdown test done");
		finish_test;
	end
endmodule
